// >>> hdl/twh_pkg.sv
// constants shared by the tuning word history control block
package twh_pkg;
	// =====================================================
	// sizes
	localparam int NDPLL      = 2;
	localparam int TW_W       = 46;
	localparam int TMR_W      = 28;
	localparam int CNT_W      = 16;
	localparam int SUM_W      = TW_W + CNT_W;
	localparam int HIST_BYTES = 6;
	localparam int NSUB       = 8;
	// =====================================================
	// register offsets, one per loop except the shared interrupt status and mask pair
	localparam logic [15:0] OFS_OPT [NDPLL] = '{16'h100E, 16'h140E};
	localparam logic [15:0] OFS_PAU [NDPLL] = '{16'h100F, 16'h140F};
	localparam logic [15:0] OFS_CLR [NDPLL] = '{16'h2107, 16'h2207};
	localparam logic [15:0] OFS_STA [NDPLL] = '{16'h3102, 16'h3202};
	localparam logic [15:0] OFS_HST [NDPLL] = '{16'h3110, 16'h3210};
	localparam logic [15:0] OFS_IRQ_ST = 16'h3000;
	localparam logic [15:0] OFS_IRQ_MK = 16'h3001;
	// =====================================================
	// field positions and reset values
	localparam int OPT_PERSIST = 0;
	localparam int OPT_SINGLE  = 1;
	localparam int OPT_QUICK   = 2;
	localparam int PAU_PLOCK   = 0;
	localparam int PAU_FLOCK   = 1;
	localparam int PAU_SLEW    = 2;
	localparam int CLR_HIST    = 1;
	localparam int STA_AVAIL   = 0;
	localparam logic [7:0] REG_RST = 8'h00;
	// =====================================================
	// subinterval progress thresholds
	localparam logic [3:0] QS_AVAIL = 4'h2;
	localparam logic [3:0] WIN_MID  = 4'h4;
	localparam logic [3:0] WIN_FULL = 4'h8;
	// =====================================================
	// timing: timer ticks every eighth of a millisecond
	localparam int CLK_NS       = 25;
	localparam int EIGHTH_MS_NS = 125000;
	localparam int CYC_EIGHTH   = EIGHTH_MS_NS / CLK_NS;
endpackage : twh_pkg

// >>> hdl/twh_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module twh_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// pins in, filtered levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;

	// shift chain; ff1 feeds only ff2
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ff1 <= '0;
			ff2 <= '0;
			ff3 <= '0;
		end else begin
			ff1 <= d;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// a bit moves only once stages two and three agree
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) q <= '0;
		else     q <= ((ff2 ~^ ff3) & ff3) | ((ff2 ^ ff3) & q);
	end
endmodule // twh_sync

// >>> hdl/twh_timer.sv
// subinterval timer: one eighth of the span per subinterval
`timescale 1ns/100ps
module twh_timer
	import twh_pkg::*;
#(
	parameter int unsigned CYC_TICK = CYC_EIGHTH
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// control side
	twh_tmr_if.tmr    tif
);
	localparam int PW = $clog2(CYC_TICK + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_TICK - 1);

	logic [PW-1:0]    pre;
	logic [TMR_W-1:0] ticks;

	// span ms * 1/8 ms ticks = span/8; a shrunken span ends at the next tick
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pre         <= '0;
			ticks       <= '0;
			tif.sub_end <= 1'b0;
		end else if (tif.restart) begin
			pre         <= '0;
			ticks       <= '0;
			tif.sub_end <= 1'b0;
		end else begin
			tif.sub_end <= 1'b0;
			if (tif.run && tif.span_ms != '0) begin
				if (pre == PRE_LAST) begin
					pre <= '0;
					if (ticks + 1'b1 >= tif.span_ms) begin
						ticks       <= '0;
						tif.sub_end <= 1'b1;
					end else begin
						ticks <= ticks + 1'b1;
					end
				end else begin
					pre <= pre + 1'b1;
				end
			end
		end
	end
endmodule // twh_timer

// >>> hdl/twh_tmr_if.sv
// link between the averaging control and its subinterval timer
`timescale 1ns/100ps
interface twh_tmr_if;
	import twh_pkg::*;
	logic             run;
	logic             restart;
	logic [TMR_W-1:0] span_ms;
	logic             sub_end;
	modport ctl (output run, restart, span_ms, input sub_end);
	modport tmr (input run, restart, span_ms, output sub_end);
endinterface : twh_tmr_if

// >>> hdl/twh_top.sv
// tuning word history control for two loops, with registers
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module twh_top
	import twh_pkg::*;
#(
	parameter int unsigned CYC_TICK = CYC_EIGHTH
) (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// register port
	input  wire logic [15:0]                 addr,
	input  wire logic [7:0]                  wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [7:0]                  rdata,
	// loop filter side, per loop
	input  wire logic [NDPLL-1:0]            lf_valid,
	input  wire logic [NDPLL-1:0][TW_W-1:0]  lf_tw,
	input  wire logic [NDPLL-1:0]            loop_closed,
	input  wire logic [NDPLL-1:0]            holdover_entry,
	input  wire logic [NDPLL-1:0][TMR_W-1:0] acc_ms,
	input  wire logic [NDPLL-1:0][TW_W-1:0]  freerun_tw,
	// loop status pins, asynchronous
	input  wire logic [NDPLL-1:0]            phase_locked,
	input  wire logic [NDPLL-1:0]            freq_locked,
	input  wire logic [NDPLL-1:0]            slew_limiting,
	// oscillator load on holdover entry
	output logic      [NDPLL-1:0]            nco_load,
	output logic      [NDPLL-1:0][TW_W-1:0]  nco_tw,
	// history status and result
	output logic      [NDPLL-1:0]            hist_avail,
	output logic      [NDPLL-1:0][TW_W-1:0]  hist_tw,
	// interrupt
	output logic                             irq
);
	// =====================================================
	// register file
	logic [7:0]       opt [NDPLL];
	logic [7:0]       pau [NDPLL];
	logic [NDPLL-1:0] clr_pulse;
	logic [NDPLL-1:0] irq_st;
	logic [NDPLL-1:0] irq_mk;
	logic [NDPLL-1:0] upd;
	logic [7:0]       rmux;

	// option and pause-enable registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NDPLL; i++) begin
				opt[i] <= REG_RST;
				pau[i] <= REG_RST;
			end
		end else if (wr) begin
			for (int i = 0; i < NDPLL; i++) begin
				if (addr == OFS_OPT[i]) opt[i] <= wdata;
				if (addr == OFS_PAU[i]) pau[i] <= wdata;
			end
		end
	end

	// clear history is a self-clearing one-cycle command
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clr_pulse <= '0;
		end else begin
			for (int i = 0; i < NDPLL; i++) begin
				clr_pulse[i] <= wr && addr == OFS_CLR[i]
					&& wdata[CLR_HIST];
			end
		end
	end

	// sticky update flags, write one to clear, set wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_st <= '0;
		end else if (wr && addr == OFS_IRQ_ST) begin
			irq_st <= (irq_st & ~wdata[NDPLL-1:0]) | upd;
		end else begin
			irq_st <= irq_st | upd;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)                            irq_mk <= '0;
		else if (wr && addr == OFS_IRQ_MK) irq_mk <= wdata[NDPLL-1:0];
	end

	// level interrupt while any unmasked flag stands
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) irq <= 1'b0;
		else     irq <= |(irq_st & irq_mk);
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		rmux = 8'h00;
		if (addr == OFS_IRQ_ST) rmux = {{(8-NDPLL){1'b0}}, irq_st};
		if (addr == OFS_IRQ_MK) rmux = {{(8-NDPLL){1'b0}}, irq_mk};
		for (int i = 0; i < NDPLL; i++) begin
			if (addr == OFS_OPT[i]) rmux = opt[i];
			if (addr == OFS_PAU[i]) rmux = pau[i];
			if (addr == OFS_STA[i]) rmux = {7'h00, hist_avail[i]};
			for (int b = 0; b < HIST_BYTES; b++) begin
				if (addr == OFS_HST[i] + 16'(b)) begin
					rmux = 8'({2'b00, hist_tw[i]} >> (8 * b));
				end
			end
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)     rdata <= 8'h00;
		else if (rd) rdata <= rmux;
		else         rdata <= 8'h00;
	end

	// =====================================================
	// status pin synchronisers
	logic [NDPLL-1:0] pl_s;
	logic [NDPLL-1:0] fl_s;
	logic [NDPLL-1:0] sl_s;

	twh_sync #(.W(3 * NDPLL)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({phase_locked, freq_locked, slew_limiting}),
		.q    ({pl_s, fl_s, sl_s})
	);

	// =====================================================
	// one independent history engine per loop
	for (genvar g = 0; g < NDPLL; g++) begin : g_dpll
		twh_tmr_if tif ();

		logic             pause_cond;
		logic             reset_avg;
		logic             run;
		logic             bypass;
		logic [SUM_W-1:0] sub_sum;
		logic [CNT_W-1:0] sub_cnt;
		logic [SUM_W-1:0] quo;
		logic [TW_W-1:0]  sub_avg;
		logic [TW_W-1:0]  last_tw;
		logic [TW_W-1:0]  ring [NSUB];
		logic [2:0]       wptr;
		logic [3:0]       done;
		logic [3:0]       next_done;
		logic [3:0]       win;
		logic [TW_W+2:0]  win_sum;
		logic [TW_W-1:0]  win_avg;
		logic             avail_now;

		twh_timer #(.CYC_TICK(CYC_TICK)) u_tmr (
			.mclk (mclk),
			.rst  (rst),
			.tif  (tif)
		);

		// enabled conditions OR together; none set, never pause
		assign pause_cond = (pau[g][PAU_PLOCK] & ~pl_s[g])
			| (pau[g][PAU_FLOCK] & ~fl_s[g])
			| (pau[g][PAU_SLEW] & sl_s[g]);
		// all enables clear keeps pause_cond low

		// reset on clear, zero span (bypass) or non-persistent pause, freeze otherwise
		assign bypass    = acc_ms[g] == '0;
		assign reset_avg = clr_pulse[g] | bypass
			| (pause_cond & ~opt[g][OPT_PERSIST]);
		assign run       = loop_closed[g] & ~pause_cond;

		// timer hookup
		assign tif.run     = run;
		assign tif.restart = reset_avg;
		assign tif.span_ms = acc_ms[g];

		// latest loop filter word, kept for single-sample holdover
		always_ff @(posedge mclk or posedge rst) begin
			if (rst)              last_tw <= '0;
			else if (lf_valid[g]) last_tw <= lf_tw[g];
		end

		// per-subinterval sum and count of samples
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				sub_sum <= '0;
				sub_cnt <= '0;
			end else if (reset_avg) begin
				sub_sum <= '0;
				sub_cnt <= '0;
			end else if (tif.sub_end) begin
				sub_sum <= (run && lf_valid[g]) ? SUM_W'(lf_tw[g]) : '0;
				sub_cnt <= (run && lf_valid[g]) ? CNT_W'(1) : '0;
			end else if (run && lf_valid[g] && sub_cnt != '1) begin
				sub_sum <= sub_sum + SUM_W'(lf_tw[g]);
				sub_cnt <= sub_cnt + 1'b1;
			end
		end

		// subinterval average; an empty one repeats the last word
		assign quo     = sub_sum / SUM_W'(sub_cnt);
		assign sub_avg = (sub_cnt == '0) ? last_tw : quo[TW_W-1:0];

		// progress after the subinterval now ending
		assign next_done = (done == WIN_FULL) ? done : done + 1'b1;

		// window grows 2, 4, 8 subintervals
		always_comb begin
			if (next_done >= WIN_FULL)     win = WIN_FULL;
			else if (next_done >= WIN_MID) win = WIN_MID;
			else                           win = QS_AVAIL;
		end

		// sum of the newest averages within the window
		always_comb begin
			win_sum = (TW_W+3)'(sub_avg);
			for (int k = 1; k < NSUB; k++) begin
				if (4'(k) < win) begin
					win_sum = win_sum + (TW_W+3)'(ring[3'(wptr - 3'(k))]);
				end
			end
		end

		// window sizes are powers of two, so divide by shifting
		always_comb begin
			if (win == WIN_FULL)     win_avg = TW_W'(win_sum >> 3);
			else if (win == WIN_MID) win_avg = TW_W'(win_sum >> 2);
			else                     win_avg = TW_W'(win_sum >> 1);
		end

		// quick start makes history after two, else after eight
		assign avail_now = opt[g][OPT_QUICK]
			? (next_done >= QS_AVAIL)
			: (next_done >= WIN_FULL);

		// ring of subinterval averages and progress count
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				wptr <= '0;
				done <= '0;
				for (int k = 0; k < NSUB; k++) ring[k] <= '0;
			end else if (reset_avg) begin
				wptr <= '0;
				done <= '0;
			end else if (tif.sub_end) begin
				ring[wptr] <= sub_avg;
				wptr       <= wptr + 1'b1;
				done       <= next_done;
			end
		end

		// available flag falls on reset, rises with first result
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				hist_avail[g] <= 1'b0;
			end else if (reset_avg) begin
				hist_avail[g] <= 1'b0;
			end else if (tif.sub_end && avail_now) begin
				hist_avail[g] <= 1'b1;
			end
		end

		// result written on a completed average, or straight from the loop filter in bypass
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				hist_tw[g] <= '0;
			end else if (bypass) begin
				if (lf_valid[g]) hist_tw[g] <= lf_tw[g];
			end else if (!reset_avg && tif.sub_end && avail_now) begin
				hist_tw[g] <= win_avg;
			end
		end

		// update strobe into the sticky flag
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) upd[g] <= 1'b0;
			else     upd[g] <= !reset_avg && tif.sub_end && avail_now;
		end

		// holdover entry picks the word by averaging progress
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				nco_load[g] <= 1'b0;
				nco_tw[g]   <= '0;
			end else begin
				nco_load[g] <= holdover_entry[g];
				if (holdover_entry[g]) begin
					if (hist_avail[g]) begin
						nco_tw[g] <= hist_tw[g];
					end else if (opt[g][OPT_SINGLE]) begin
						nco_tw[g] <= last_tw;
					end else begin
						nco_tw[g] <= freerun_tw[g];
					end
				end
			end
		end
	end
endmodule // twh_top

// >>> tb/twh_top_asserts.sv
// port checks for the tuning word history control top
`timescale 1ns/100ps
module twh_top_asserts
	import twh_pkg::*;
#(
	parameter int unsigned CYC_TICK = CYC_EIGHTH
) (
	// clock and reset
	input wire logic                        mclk,
	input wire logic                        rst,
	// register port
	input wire logic [15:0]                 addr,
	input wire logic [7:0]                  wdata,
	input wire logic                        wr,
	input wire logic                        rd,
	input wire logic [7:0]                  rdata,
	// loop side
	input wire logic [NDPLL-1:0]            holdover_entry,
	input wire logic [NDPLL-1:0][TMR_W-1:0] acc_ms,
	input wire logic [NDPLL-1:0][TW_W-1:0]  freerun_tw,
	// results
	input wire logic [NDPLL-1:0]            nco_load,
	input wire logic [NDPLL-1:0][TW_W-1:0]  nco_tw,
	input wire logic [NDPLL-1:0]            hist_avail,
	input wire logic [NDPLL-1:0][TW_W-1:0]  hist_tw
);
	// =====================================================
	// shadow of loop 0 options, pause enables and recent clears
	logic [7:0] opt0;
	logic [7:0] pau0;
	logic [3:0] clr_age;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			opt0 <= 8'h00;
			pau0 <= 8'h00;
			clr_age <= 4'h0;
		end else begin
			if (wr && addr == OFS_OPT[0]) opt0 <= wdata;
			if (wr && addr == OFS_PAU[0]) pau0 <= wdata;
			clr_age <= {clr_age[2:0],
				wr && addr == OFS_CLR[0] && wdata[CLR_HIST]};
		end
	end
	// =====================================================
	// properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_clear;
		wr && addr == OFS_CLR[0] && wdata[CLR_HIST];
	endsequence
	sequence s_entry_empty;
		holdover_entry[0] && !hist_avail[0] && !opt0[OPT_SINGLE];
	endsequence
	a_load_follows: assert property (
		holdover_entry[0] |=> nco_load[0])
		else $error("no oscillator load after holdover entry");
	a_load_cause: assert property (
		nco_load[0] |-> $past(holdover_entry[0]))
		else $error("oscillator load without holdover entry");
	a_free_word: assert property (
		s_entry_empty |=> nco_tw[0] == $past(freerun_tw[0]))
		else $error("free-run word not loaded");
	a_hist_word: assert property (holdover_entry[0] && hist_avail[0]
		|=> nco_tw[0] == $past(hist_tw[0]))
		else $error("history word not loaded");
	a_clear_drops: assert property (s_clear |-> ##3 !hist_avail[0])
		else $error("history available survived a clear");
	a_clear_keeps: assert property (s_clear
		|=> (hist_tw[0] == $past(hist_tw[0])) [*3])
		else $error("history result changed by a clear");
	a_tw_update: assert property (hist_tw[0] != $past(hist_tw[0])
		|-> hist_avail[0] || acc_ms[0] == '0)
		else $error("history result changed without history");
	a_avail_fall: assert property (
		$fell(hist_avail[0])
		|-> (pau0[2:0] != 3'h0 && !opt0[OPT_PERSIST])
		|| clr_age != 4'h0)
		else $error("history available fell without cause");
	a_read_opt: assert property (
		$past(rd && addr == OFS_OPT[0]) |-> rdata == opt0)
		else $error("options read back wrong");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule // twh_top_asserts

bind twh_top twh_top_asserts #(.CYC_TICK(CYC_TICK)) twh_top_asserts_inst (
	.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .holdover_entry(holdover_entry), .acc_ms(acc_ms),
	.freerun_tw(freerun_tw), .nco_load(nco_load), .nco_tw(nco_tw),
	.hist_avail(hist_avail), .hist_tw(hist_tw)
);

// >>> tb/twh_top_tb.sv
// register-level testbench of the tuning word history control top
`timescale 1ns/100ps
module twh_top_tb import twh_pkg::*;;
	localparam int TICK = 4;
	localparam logic [TW_W-1:0] W0 = 46'h1234_5678_9AB;
	localparam logic [TW_W-1:0] W2 = 46'h0F0F_0F0F_0F0;
	localparam logic [TW_W-1:0] F0 = 46'h2000_0000_000;
	localparam logic [TW_W-1:0] F1 = 46'h1555_5555_555;
	logic mclk, rst, wr, rd, irq;
	logic [15:0] addr;
	logic [7:0] wdata, rdata;
	logic [NDPLL-1:0] lf_valid, loop_closed, holdover_entry, nco_load;
	logic [NDPLL-1:0] phase_locked, freq_locked, slew_limiting, hist_avail;
	logic [NDPLL-1:0][TW_W-1:0] lf_tw, freerun_tw, nco_tw, hist_tw;
	logic [NDPLL-1:0][TMR_W-1:0] acc_ms;
	int err_total, n_checks, i;
	twh_top #(.CYC_TICK(TICK)) twh_top_inst (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .lf_valid(lf_valid), .lf_tw(lf_tw),
		.loop_closed(loop_closed), .holdover_entry(holdover_entry),
		.acc_ms(acc_ms), .freerun_tw(freerun_tw),
		.phase_locked(phase_locked), .freq_locked(freq_locked),
		.slew_limiting(slew_limiting), .nco_load(nco_load),
		.nco_tw(nco_tw), .hist_avail(hist_avail), .hist_tw(hist_tw),
		.irq(irq)
	);
	// =====================================================
	// clock
	always #12.5 mclk = ~mclk;
	// =====================================================
	// access and compare tasks
	task check(input string name, input logic [TW_W-1:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 check("rdata", TW_W'(rdata), TW_W'(e));
	endtask
	task av(input logic e);
		#1 check("hist_avail", TW_W'(hist_avail[0]), TW_W'(e));
	endtask
	task ho(input int x, input logic [TW_W-1:0] e);
		@(posedge mclk);
		holdover_entry[x] <= 1'b1;
		@(posedge mclk);
		holdover_entry[x] <= 1'b0;
		#1 check("nco_load", TW_W'(nco_load[x]), TW_W'(1'b1));
		check("nco_tw", nco_tw[x], e);
	endtask
	task bad(input logic [2:0] b);
		@(posedge mclk);
		phase_locked[0] <= ~b[0];
		freq_locked[0] <= ~b[1];
		slew_limiting[0] <= b[2];
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// =====================================================
	// watchdog
	initial begin
		#(25 * 4000);
		err_total++;
		complete_run();
	end
	// =====================================================
	// main sequence
	initial begin
		{mclk, rst, wr, rd, addr, wdata, err_total, n_checks} = '0;
		rst = 1'b1;
		{lf_valid, phase_locked, freq_locked} = '1;
		{loop_closed, holdover_entry, slew_limiting} = '0;
		lf_tw = {46'h0AAA_5555_333, W0};
		freerun_tw = {F1, F0};
		acc_ms = {28'h0000001, 28'h0000001};
		cyc(5);
		rst <= 1'b0;
		for (i = 0; i < NDPLL; i++) begin
			rd_reg(OFS_OPT[i], REG_RST);
			rd_reg(OFS_PAU[i], REG_RST);
			rd_reg(OFS_CLR[i], REG_RST);
		end
		wr_reg(OFS_PAU[1], 8'hA5);
		rd_reg(OFS_PAU[1], 8'hA5);
		rd_reg(OFS_PAU[0], REG_RST);
		wr_reg(OFS_PAU[1], REG_RST);
		rd_reg(16'h0000, 8'h00);
		$display("test registers done");
		loop_closed[0] <= 1'b1;
		wr_reg(OFS_CLR[0], 8'h02);
		ho(0, F0);
		wr_reg(OFS_OPT[0], 8'h02);
		ho(0, W0);
		ho(1, F1);
		$display("test holdover done");
		wr_reg(OFS_OPT[0], 8'h00);
		wr_reg(OFS_CLR[0], 8'h02);
		cyc(24);
		av(1'b0);
		cyc(14);
		av(1'b1);
		check("hist_tw", hist_tw[0], W0);
		rd_reg(OFS_STA[0], 8'h01);
		rd_reg(OFS_HST[0], W0[7:0]);
		rd_reg(OFS_HST[0] + 16'h0005, {2'b00, W0[45:40]});
		check("hist_tw1", hist_tw[1], '0);
		rd_reg(OFS_IRQ_ST, 8'h01);
		ho(0, W0);
		wr_reg(OFS_IRQ_MK, 8'h01);
		cyc(2);
		#1 check("irq", TW_W'(irq), TW_W'(1'b1));
		loop_closed[0] <= 1'b0;
		cyc(8);
		wr_reg(OFS_IRQ_ST, 8'h03);
		rd_reg(OFS_IRQ_ST, 8'h00);
		check("irq", TW_W'(irq), TW_W'(1'b0));
		wr_reg(OFS_IRQ_MK, 8'h00);
		loop_closed[0] <= 1'b1;
		cyc(8);
		rd_reg(OFS_IRQ_ST, 8'h01);
		check("irq", TW_W'(irq), TW_W'(1'b0));
		$display("test normal mode done");
		loop_closed[0] <= 1'b0;
		lf_tw[0] <= W2;
		wr_reg(OFS_CLR[0], 8'h02);
		cyc(3);
		av(1'b0);
		check("hist_tw", hist_tw[0], W0);
		wr_reg(OFS_OPT[0], 8'h04);
		loop_closed[0] <= 1'b1;
		cyc(6);
		av(1'b0);
		cyc(6);
		av(1'b1);
		check("hist_tw", hist_tw[0], W2);
		$display("test quick start done");
		bad(3'b111);
		cyc(10);
		av(1'b1);
		bad(3'b000);
		for (i = 0; i < 4; i++) begin
			wr_reg(OFS_PAU[0], (i < 3) ? (8'h01 << i) : 8'h07);
			bad((i < 3) ? (3'b001 << i) : 3'b100);
			cyc(8);
			av(1'b0);
			bad(3'b000);
			cyc(16);
			av(1'b1);
		end
		wr_reg(OFS_OPT[0], 8'h05);
		wr_reg(OFS_PAU[0], 8'h01);
		bad(3'b001);
		cyc(6);
		lf_tw[0] <= 46'h3FFF_0000_111;
		cyc(12);
		av(1'b1);
		check("hist_tw", hist_tw[0], W2);
		$display("test pause done");
		complete_run();
	end
endmodule // twh_top_tb
